// ### hw/sio_regs.svh
// register map, field positions, encodings and timing of the buffered serial shift engine
// assumes an 8-bit register port with a 5-bit address
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH

// register addresses
`define A_CTRL1        5'h00
`define A_CTRL2        5'h01
`define A_STAT         5'h02
`define BUF_SEL        2'b01
`define BUF_SEL_HI     4
`define BUF_SEL_LO     3

// serial_control_one fields
`define C1_START       7
`define C1_ABORT       6
`define C1_MODE_HI     5
`define C1_MODE_LO     3
`define C1_EXTCLK      0

// serial_control_two fields
`define C2_CNT_HI      2
`define C2_CNT_LO      0

// serial_status fields
`define ST_BUSY        7
`define ST_SHIFT       6

// reset values
`define CTRL1_RST      8'h00
`define CNT_RST        3'h0
`define BYTE_ZERO      8'h00
`define NIB_ZERO       4'h0

// last and first bit index of a word, first word index
`define LAST_BIT8      3'h7
`define LAST_BIT4      3'h3
`define BIT_FIRST      3'h0
`define IDX_FIRST      3'h0

// internal serial clock: half period in ns, clk period in ns
`define SCK_HALF_NS    100
`define CLK_PERIOD_NS  25
`define SCK_HALF_CYC   (`SCK_HALF_NS / `CLK_PERIOD_NS)

`endif

// ### hw/sio_pkg.sv
// types shared by the buffered serial shift engine
// assumes sio_regs.svh for numeric constants
package sio_pkg;

  typedef enum logic [2:0] {
    mode_tx8 = 3'b000,
    mode_tx4 = 3'b010,
    mode_dup = 3'b100,
    mode_rx8 = 3'b101,
    mode_rx4 = 3'b110
  } mode_t;

  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_shift = 3'b010,
    st_wait  = 3'b100
  } state_t;

endpackage

// ### hw/clocked_serial_buffered_xfer.sv
// clocked serial shift engine with an eight-word data buffer, lsb first
// assumes one 40 MHz clock; serial pins are asynchronous and are synchronised here
//
// Contract
// - transmit bits change on clock falling edge
// - receive bits sampled on clock rising edge
// - 4-bit mode: low nibble, zero upper nibble
// - every word shifted lsb first
// - transfer one to eight words unattended
// - interrupt after programmed word count, but not when a dummy, dropped or start-cleared receive word ends the group
// - count rewrite only when stopped or waiting
// - next buffer word loaded as lsb leaves
// - buffer empty interrupt after last bit
// - internal clock transmit: stall without new data
// - any buffer write releases transmit wait
// - external transmit without data: dummy, then end
// - start cleared: finish words, clear busy
// - abort ends transfer at once, clear busy
// - received word stored from lowest location up
// - internal receive: stall until a read
// - external receive unread: drop word, stop
// - start cleared receiving: finish word, stop
// - buffer lost on mode change
// - duplex internal: stall until a write
// - busy flag one while transfer runs
// - internal clock driven out, idles high
`include "sio_regs.svh"
`timescale 1ns/1ps

module clocked_serial_buffered_xfer
  import sio_pkg::*;
(
  input  wire logic       clk,                     // 40 MHz system clock
  input  wire logic       srst,                    // synchronous reset, active high
  input  wire logic [4:0] addr,                    // register address
  input  wire logic [7:0] wdata,                   // register write data
  input  wire logic       wr,                      // write strobe
  input  wire logic       rd,                      // read strobe
  output logic      [7:0] rdata,                   // read data, cycle after rd
  input  wire logic       serial_clock_pin_i,      // clock pin level
  output logic            serial_clock_pin_o,      // clock pin drive value
  output logic            serial_clock_pin_oe,     // clock pin drive enable
  output logic            serial_data_out_pin_one, // serial data out
  input  wire logic       serial_data_in_pin_one,  // serial data in
  output logic            serial_done_interrupt    // word count reached, one-cycle pulse
);

  state_t     state_q;
  mode_t      mode_q;
  logic       ext_q;
  logic       start_q;
  logic [2:0] cnt_q;
  logic [2:0] idx_q;
  logic [2:0] bit_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic [7:0] buf_q [8];
  logic       touched_q;
  logic       last_q;
  logic       unread_q;
  logic       sdo_q;
  logic       sck_q;
  logic       done_q;
  logic [2:0] div_q;
  logic       sck_s1_q;
  logic       sck_s2_q;
  logic       sck_s3_q;
  logic       si_s1_q;
  logic       si_s2_q;

  // decode: {valid, transmits, receives, four-bit}
  function automatic logic [3:0] mode_decode(input logic [2:0] m);
    case (m)
      mode_tx8: mode_decode = 4'b1100;
      mode_tx4: mode_decode = 4'b1101;
      mode_dup: mode_decode = 4'b1110;
      mode_rx8: mode_decode = 4'b1010;
      mode_rx4: mode_decode = 4'b1011;
      default:  mode_decode = 4'b0000;
    endcase
  endfunction

  logic [3:0] md;
  logic [3:0] md_new;
  logic       m_tx;
  logic       m_rx;
  logic       m_w4;
  logic       new_valid;
  assign md        = mode_decode(mode_q);
  assign m_tx      = md[2];
  assign m_rx      = md[1];
  assign m_w4      = md[0];
  assign md_new    = mode_decode(wdata[`C1_MODE_HI:`C1_MODE_LO]);
  assign new_valid = md_new[3];

  logic wr_c1;
  logic wr_c2;
  logic buf_hit;
  logic buf_wr;
  logic buf_rd;
  logic abort_req;
  logic start_go;
  logic idle;
  assign buf_hit   = addr[`BUF_SEL_HI:`BUF_SEL_LO] == `BUF_SEL;
  assign wr_c1     = wr && (addr == `A_CTRL1);
  assign wr_c2     = wr && (addr == `A_CTRL2);
  assign buf_wr    = wr && buf_hit;
  assign buf_rd    = rd && buf_hit;
  assign abort_req = wr_c1 && wdata[`C1_ABORT];
  assign idle      = state_q == st_idle;
  // mode and clock source come from the same write that sets start
  assign start_go  = wr_c1 && wdata[`C1_START] && !wdata[`C1_ABORT] && idle && new_valid;

  // pin synchronisers; logic uses the second data stage, and the second and third clock stages for edge detection
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      si_s1_q  <= 1'b1;
      si_s2_q  <= 1'b1;
    end
    else
    begin
      sck_s1_q <= serial_clock_pin_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= serial_data_in_pin_one;
      si_s2_q  <= si_s1_q;
    end
  end

  // control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_q <= 1'b0;
      mode_q  <= mode_tx8;
      ext_q   <= 1'b0;
      cnt_q   <= `CNT_RST;
    end
    else
    begin
      if (wr_c1)
      begin
        start_q <= wdata[`C1_START] && !wdata[`C1_ABORT];
        if (idle)
        begin
          mode_q <= mode_t'(wdata[`C1_MODE_HI:`C1_MODE_LO]);
          ext_q  <= wdata[`C1_EXTCLK];
        end
      end
      if (wr_c2 && (idle || state_q == st_wait))
        cnt_q <= wdata[`C2_CNT_HI:`C2_CNT_LO];
    end
  end

  // internal serial clock divider
  logic tick;
  logic shifting;
  assign shifting = state_q == st_shift;
  assign tick     = !ext_q && shifting && (div_q == 3'(`SCK_HALF_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (srst || !shifting || tick)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // pin clock idles high and stays high while stalled
  always_ff @(posedge clk)
  begin
    if (srst || !shifting)
      sck_q <= 1'b1;
    else if (tick)
      sck_q <= !sck_q;
  end

  logic fall_ev;
  logic rise_ev;
  assign fall_ev = shifting && (ext_q ? (sck_s3_q && !sck_s2_q) : (tick && sck_q));
  assign rise_ev = shifting && (ext_q ? (!sck_s3_q && sck_s2_q) : (tick && !sck_q));

  logic       word_done;
  logic       group_end;
  logic       access;
  logic       touch_now;
  logic       drop_word;
  logic [7:0] rx_val;
  assign word_done = rise_ev && (bit_q == (m_w4 ? `LAST_BIT4 : `LAST_BIT8));
  assign group_end = word_done && (idx_q == cnt_q);
  // transmit and duplex wait on a buffer write, receive waits on a buffer read
  assign access    = m_tx ? buf_wr : buf_rd;
  assign touch_now = touched_q || access;
  assign drop_word = m_rx && ext_q && unread_q && !buf_rd;
  assign rx_val    = m_w4 ? {`NIB_ZERO, si_s2_q, rx_sh_q[7:5]}
                          : {si_s2_q, rx_sh_q[7:1]};

  // transmit side: bits leave on the falling edge
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sdo_q   <= 1'b1;
      tx_sh_q <= `BYTE_ZERO;
    end
    else if (fall_ev && m_tx)
    begin
      if (bit_q == `BIT_FIRST)
      begin
        sdo_q   <= buf_q[idx_q][0];
        tx_sh_q <= buf_q[idx_q] >> 1;
      end
      else
      begin
        sdo_q   <= tx_sh_q[0];
        tx_sh_q <= tx_sh_q >> 1;
      end
    end
    else if (idle)
      sdo_q <= 1'b1;
  end

  // receive side: bits enter on the rising edge
  always_ff @(posedge clk)
  begin
    if (srst)
      rx_sh_q <= `BYTE_ZERO;
    else if (rise_ev)
      rx_sh_q <= {si_s2_q, rx_sh_q[7:1]};
  end

  // sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q   <= st_idle;
      idx_q     <= `IDX_FIRST;
      bit_q     <= `BIT_FIRST;
      last_q    <= 1'b0;
      unread_q  <= 1'b0;
      done_q    <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (buf_rd)
        unread_q <= 1'b0;
      if (abort_req)
        state_q <= st_idle;
      else if (start_go)
      begin
        state_q  <= st_shift;
        idx_q    <= `IDX_FIRST;
        bit_q    <= `BIT_FIRST;
        last_q   <= 1'b0;
        unread_q <= 1'b0;
      end
      else if (state_q == st_wait)
      begin
        if (access)
          state_q <= st_shift;
        else if (!start_q)
          state_q <= st_idle;
      end
      else if (rise_ev && !word_done)
        bit_q <= bit_q + 3'h1;
      else if (word_done)
      begin
        bit_q <= `BIT_FIRST;
        if (drop_word)
          state_q <= st_idle;
        else if (last_q)
          state_q <= st_idle;
        else if (!start_q && m_rx && !m_tx)
          state_q <= st_idle;
        else if (group_end)
        begin
          done_q <= 1'b1;
          idx_q  <= `IDX_FIRST;
          if (!start_q)
            state_q <= st_idle;
          else if (!ext_q && !touch_now)
            state_q <= st_wait;
          else if (ext_q && m_tx && !m_rx && !touch_now)
            last_q <= 1'b1;
          else if (ext_q && m_rx && !buf_rd)
            unread_q <= 1'b1;
        end
        else
          idx_q <= idx_q + 3'h1;
      end
    end
  end

  // set by an access wins over the clear at the end of a group; the access that
  // releases a wait is used up by that release, else the next group would run unfed
  always_ff @(posedge clk)
  begin
    if (srst || start_go)
      touched_q <= 1'b0;
    else if (access && (state_q != st_wait))
      touched_q <= 1'b1;
    else if (group_end || (state_q == st_wait))
      touched_q <= 1'b0;
  end

  // data buffer: software side and received words; wiped on a mode change
  always_ff @(posedge clk)
  begin
    if (srst || (wr_c1 && idle && (wdata[`C1_MODE_HI:`C1_MODE_LO] != mode_q)))
    begin
      for (int i = 0; i < 8; i++)
        buf_q[i] <= `BYTE_ZERO;
    end
    else if (word_done && m_rx && !drop_word && !abort_req)
      buf_q[idx_q] <= rx_val;
    else if (buf_wr)
      buf_q[addr[2:0]] <= wdata;
  end

  // read port; control registers are write-only and read zero
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= `BYTE_ZERO;
    else if (buf_rd)
      rdata <= buf_q[addr[2:0]];
    else if (rd && addr == `A_STAT)
      rdata <= {!idle, shifting, 6'h00};
    else
      rdata <= `BYTE_ZERO;
  end

  assign serial_clock_pin_o      = sck_q;
  assign serial_clock_pin_oe     = !ext_q;
  assign serial_data_out_pin_one = sdo_q;
  assign serial_done_interrupt   = done_q;

  property p_abort;
    @(posedge clk) disable iff (srst)
    abort_req |=> (state_q == st_idle) ##1 (rdata[`ST_BUSY] == 1'b0 || !$past(rd));
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop transfer");

  property p_out_edge;
    @(posedge clk) disable iff (srst)
    (!idle && $changed(sdo_q)) |-> $past(fall_ev);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("data out moved off falling edge");

  property p_in_edge;
    @(posedge clk) disable iff (srst)
    (shifting && !rise_ev && !abort_req) |=> $stable(bit_q);
  endproperty
  a_in_edge: assert property (p_in_edge) else $error("bit count moved off rising edge");

  property p_nibble;
    @(posedge clk) disable iff (srst)
    (word_done && m_rx && m_w4 && !drop_word && !abort_req)
      |=> buf_q[$past(idx_q)][7:4] == `NIB_ZERO;
  endproperty
  a_nibble: assert property (p_nibble) else $error("upper nibble not zero");

  property p_group;
    @(posedge clk) disable iff (srst)
    serial_done_interrupt |-> (idx_q == `IDX_FIRST) && $past(idx_q == cnt_q);
  endproperty
  a_group: assert property (p_group) else $error("interrupt not at word count");

  property p_idle_high;
    @(posedge clk) disable iff (srst)
    (!ext_q && !shifting) |=> serial_clock_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock pin not high when stalled");

  property p_busy_rise;
    @(posedge clk) disable iff (srst)
    $fell(idle) |-> $past(start_go);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy without start");

  property p_count_hold;
    @(posedge clk) disable iff (srst)
    (wr_c2 && shifting) |=> $stable(cnt_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count changed while shifting");

  property p_release;
    @(posedge clk) disable iff (srst)
    (state_q == st_wait && m_tx && buf_wr && !abort_req) |=> shifting;
  endproperty
  a_release: assert property (p_release) else $error("buffer write did not release wait");

endmodule // clocked_serial_buffered_xfer

// ### tb/sio_peer.sv
// far-side serial peripheral: records what the device shifts out and feeds a pattern in
// assumes sck is the resolved clock pin level, which idles high
`timescale 1ns/1ps

module sio_peer
(
  input  wire logic       sck,     // resolved clock pin level
  input  wire logic       sdo,     // device serial out
  input  wire logic       clr,     // clears record and counter
  input  wire logic       ext_go,  // rising edge starts one 8-bit clock burst
  input  wire logic [7:0] pat,     // bits fed to the device, lsb first
  output logic            sdi,     // device serial in
  output logic            ext_sck, // external clock, stands high between bursts
  output logic      [7:0] cap,     // last bits seen, newest in bit 7
  output logic      [7:0] n_rise   // clock rising edges seen
);
  initial
  begin
    sdi     = 1'b1;
    ext_sck = 1'b1;
    cap     = 8'h00;
    n_rise  = 8'h00;
  end

  // sample where the device launched a bit half a period earlier
  always @(posedge sck or posedge clr)
    if (clr)
    begin
      cap    <= 8'h00;
      n_rise <= 8'h00;
    end
    else
    begin
      cap    <= {sdo, cap[7:1]};
      n_rise <= n_rise + 8'h01;
    end

  // new bit on the falling edge so it is settled well before the device samples it
  always @(negedge sck)
    sdi <= pat[n_rise[2:0]];

  // odd start offset keeps the burst unrelated in phase to the system clock
  always @(posedge ext_go)
  begin
    #37;
    repeat (8)
    begin
      #100 ext_sck = 1'b0;
      #100 ext_sck = 1'b1;
    end
  end
endmodule // sio_peer

// ### tb/clocked_serial_buffered_xfer_tb_top.sv
// self-checking bench for the buffered serial shift engine
// assumes sio_regs.svh and sio_pkg are compiled and sio_peer sits on the serial pins
`include "sio_regs.svh"
`timescale 1ns/1ps

module clocked_serial_buffered_xfer_tb_top
  import sio_pkg::*;
;
  typedef struct packed {
    logic [2:0] m;
    logic [7:0] tx;
    logic [7:0] pat;
    logic [7:0] cap_x;
    logic [7:0] cap_m;
    logic [7:0] rx_x;
    logic [7:0] rx_m;
  } row_t;

  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       clr = 1'b0;
  logic       ext_go = 1'b0;
  logic [7:0] pat = 8'h00;
  logic [7:0] v;
  logic [7:0] rdata, cap, n_rise;
  logic       sck_o, sck_oe, sck_pin, ext_sck, sdo, sdi, irq;
  int         err_count = 0;
  int         n_checks = 0;
  row_t       rows [5];

  assign sck_pin = sck_oe ? sck_o : ext_sck;

  clocked_serial_buffered_xfer dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_clock_pin_i(sck_pin),
    .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .serial_data_out_pin_one(sdo), .serial_data_in_pin_one(sdi),
    .serial_done_interrupt(irq));

  sio_peer peer (.sck(sck_pin), .sdo(sdo), .clr(clr), .ext_go(ext_go), .pat(pat),
    .sdi(sdi), .ext_sck(ext_sck), .cap(cap), .n_rise(n_rise));

  always #12.5 clk = ~clk;

  task results;
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rreg(input logic [4:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  task wait_irq(input int n);
    int i;
    for (i = 0; i < n && irq !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irq", 8'h01, {7'h00, irq});
    if (irq !== 1'b1)
      results();
  endtask

  task wait_idle;
    logic [7:0] s;
    int         i;
    s = 8'hff;
    for (i = 0; i < 100 && s[7] !== 1'b0; i++)
      rreg(`A_STAT, s);
    chk("busy", 8'h00, {s[7], 7'h00});
    if (s[7] !== 1'b0)
      results();
  endtask

  initial
  begin
    // mode, tx word, peer pattern, expected capture and mask, expected buffer and mask
    rows[0] = '{mode_tx8, 8'ha5, 8'h00, 8'ha5, 8'hff, 8'ha5, 8'hff};
    rows[1] = '{mode_tx4, 8'h3c, 8'h00, 8'hc0, 8'hf0, 8'h3c, 8'hff};
    rows[2] = '{mode_rx8, 8'h00, 8'hc6, 8'hff, 8'hff, 8'hc6, 8'hff};
    rows[3] = '{mode_rx4, 8'h00, 8'he9, 8'hf0, 8'hf0, 8'h09, 8'hff};
    rows[4] = '{mode_dup, 8'h5e, 8'h71, 8'h5e, 8'hff, 8'h71, 8'hff};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1 chk("idle pins", 8'h07, {5'h00, sck_o, sck_oe, sdo});
    rreg(`A_STAT, v);
    chk("status", 8'h00, v);
    foreach (rows[k])
    begin
      clr <= 1'b1;
      pat <= rows[k].pat;
      wreg(`A_CTRL1, {2'b00, rows[k].m, 3'b000});
      clr <= 1'b0;
      wreg(`A_CTRL2, 8'h00);
      wreg(5'h08, rows[k].tx);
      wreg(`A_CTRL1, {2'b10, rows[k].m, 3'b000});
      wait_irq(200);
      chk("capture", rows[k].cap_x, cap & rows[k].cap_m);
      rreg(`A_STAT, v);
      chk("stalled", 8'h80, v);
      rreg(5'h08, v);
      chk("buffer", rows[k].rx_x, v & rows[k].rx_m);
      wreg(`A_CTRL1, {2'b00, rows[k].m, 3'b000});
      wait_idle();
    end
    // three-word group, automatic wait, count rewrite inside the wait
    clr <= 1'b1;
    wreg(`A_CTRL1, 8'h00);
    clr <= 1'b0;
    wreg(5'h08, 8'h11);
    wreg(5'h09, 8'h22);
    wreg(5'h0a, 8'h33);
    wreg(`A_CTRL2, 8'h02);
    wreg(`A_CTRL1, 8'h80);
    wait_irq(600);
    chk("bits sent", 8'h18, n_rise);
    chk("last word", 8'h33, cap);
    repeat (20) @(posedge clk);
    rreg(`A_STAT, v);
    chk("stalled", 8'h80, v);
    chk("clock held", 8'h18, n_rise);
    wreg(`A_CTRL2, 8'h00);
    wreg(5'h0f, 8'h00);
    wait_irq(200);
    chk("bits sent", 8'h20, n_rise);
    repeat (80) @(posedge clk);
    chk("clock held", 8'h20, n_rise);
    wreg(`A_CTRL1, 8'h00);
    wait_idle();
    // abort in mid-group
    wreg(`A_CTRL2, 8'h07);
    wreg(`A_CTRL1, 8'h80);
    repeat (20) @(posedge clk);
    wreg(`A_CTRL1, 8'h40);
    rreg(`A_STAT, v);
    chk("abort", 8'h00, v);
    // reserved mode refuses the start
    wreg(`A_CTRL1, 8'h38);
    wreg(`A_CTRL1, 8'hb8);
    rreg(`A_STAT, v);
    chk("reserved", 8'h00, v);
    rreg(5'h08, v);
    chk("mode wipe", 8'h00, v);
    // duplex on an external clock: both directions cross in one word
    clr <= 1'b1;
    pat <= 8'h9b;
    wreg(`A_CTRL1, {2'b00, mode_dup, 3'b001});
    clr <= 1'b0;
    #1 chk("oe ext", 8'h00, {7'h00, sck_oe});
    wreg(`A_CTRL2, 8'h00);
    wreg(5'h08, 8'h64);
    wreg(`A_CTRL1, {2'b10, mode_dup, 3'b001});
    ext_go <= 1'b1;
    wait_irq(400);
    ext_go <= 1'b0;
    chk("ext capture", 8'h64, cap);
    rreg(5'h08, v);
    chk("ext buffer", 8'h9b, v);
    wreg(`A_CTRL1, 8'h40);
    wait_idle();
    // external receive left unread: the next word is dropped and the unit stops
    clr <= 1'b1;
    pat <= 8'h3a;
    wreg(`A_CTRL1, {2'b00, mode_rx8, 3'b001});
    clr <= 1'b0;
    wreg(`A_CTRL1, {2'b10, mode_rx8, 3'b001});
    ext_go <= 1'b1;
    wait_irq(400);
    ext_go <= 1'b0;
    pat <= 8'hc5;
    @(posedge clk);
    ext_go <= 1'b1;
    repeat (90) @(posedge clk);
    ext_go <= 1'b0;
    rreg(`A_STAT, v);
    chk("rx stop", 8'h00, v);
    rreg(5'h08, v);
    chk("rx kept", 8'h3a, v);
    // external transmit with no fresh data: one dummy word, then the unit stops
    clr <= 1'b1;
    wreg(`A_CTRL1, 8'h01);
    clr <= 1'b0;
    wreg(5'h08, 8'h5a);
    wreg(`A_CTRL1, 8'h81);
    ext_go <= 1'b1;
    wait_irq(400);
    ext_go <= 1'b0;
    chk("tx word", 8'h5a, cap);
    @(posedge clk);
    ext_go <= 1'b1;
    repeat (90) @(posedge clk);
    ext_go <= 1'b0;
    rreg(`A_STAT, v);
    chk("tx stop", 8'h00, v);
    chk("tx clocks", 8'h10, n_rise);
    results();
  end
endmodule // clocked_serial_buffered_xfer_tb_top
